/* File: pkg/boot_loader_pkg.sv */
// shared constants and types for the boot mode select loader
package boot_loader_pkg;

	// ======================================================
	// kernel transfer
	localparam int          KERNEL_WORDS  = 256;
	localparam int          WORD_W        = 48;
	localparam int          IADDR_W       = 20;
	localparam int          EADDR_W       = 24;
	localparam logic [5:0]  UNIT_EPROM    = 6'h08;
	localparam logic [5:0]  UNIT_HOST8    = 6'h08;
	localparam logic [5:0]  UNIT_HOST16   = 6'h10;
	localparam logic [5:0]  UNIT_LINK     = 6'h04;
	localparam logic [5:0]  WORD_BITS     = 6'h30;

	// ======================================================
	// variants and channels
	localparam logic [1:0]  VAR_SMALL     = 2'h0;
	localparam logic [1:0]  VAR_LARGE     = 2'h1;
	localparam logic [1:0]  VAR_ONE_SEL   = 2'h2;
	localparam logic [3:0]  CH_SIX        = 4'h6;
	localparam logic [3:0]  CH_EIGHT      = 4'h8;
	localparam logic [3:0]  CH_TEN        = 4'ha;
	localparam logic [2:0]  LINK_BUFFER   = 3'h4;

	// ======================================================
	// software registers
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_COUNT     = 8'h08;
	localparam int          CTRL_OVERRIDE = 0;
	localparam int          CTRL_TRISTATE = 1;
	localparam int          CTRL_HOST16   = 2;
	localparam logic [2:0]  CTRL_RESET    = 3'h1;

	typedef enum logic [2:0] {
		MODE_NONE,
		MODE_EPROM,
		MODE_HOST,
		MODE_LINK,
		MODE_RESERVED
	} mode_t;

	typedef enum logic [2:0] {
		S_SAMPLE,
		S_START,
		S_FETCH,
		S_WAIT,
		S_COLLECT,
		S_RUN,
		S_DONE,
		S_HALT
	} state_t;

endpackage

/* File: src/boot_mode_select_loader.sv */
// boot strap decode, kernel word assembly and boot dma sequencing
//
// Behaviour
// - after reset, set up boot dma for 256 kernel words of 48 bits
// - assemble incoming boot data into 48-bit words before writing memory
// - small variants use channel 6; large uses 8 for link, 10 otherwise
// - eprom boot fetches bytes from external eprom via external port
// - host boot accepts 8-bit or 16-bit host data on external port
// - link boot takes nibbles into link buffer 4
// - after kernel load, execution starts at the variant start address
// - eprom strap high, link strap low: eprom boot, select pin becomes eprom chip select
// - eprom strap low, select high: link strap high picks link, low picks host
// - both straps and select low: no boot; other combos reserved
// - only the current bus master drives the select output
// - select output can be floated in eprom boot mode
// - single-select variant: select strap high starts byte eprom boot
// - single-select variant: strap low, select input picks host or none
// - single-select no-boot runs from external address 0x20004
// - single-select host boot defaults to byte-wide host bus
// - eprom bytes pack low byte first until 256 words are loaded
// - clearing override bit releases select pin, enables normal selects
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

module boot_mode_select_loader
	import boot_loader_pkg::*;
#(
	parameter logic [1:0]         VARIANT     = VAR_SMALL,
	parameter logic [IADDR_W-1:0] START_ADDR  = 20'h20000,
	parameter logic [IADDR_W-1:0] NOBOOT_ADDR = 20'h20004,
	parameter logic [EADDR_W-1:0] EPROM_BASE  = 24'h400000
) (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               eprom_boot_strap,
	input  wire logic               link_boot_strap,
	input  wire logic               eprom_select_strap,
	input  wire logic               bootMemorySelectIn_n,
	output logic                    bootMemorySelectOut_n,
	output logic                    bootMemorySelectOe_n,
	input  wire logic               busMaster,
	output logic                    extSelectEnable,
	output logic                    epromReq,
	output logic [EADDR_W-1:0]      epromAddr,
	input  wire logic               extValid,
	input  wire logic [15:0]        extData,
	input  wire logic               linkValid,
	input  wire logic [3:0]         linkData,
	output logic                    memWrite,
	output logic [IADDR_W-1:0]      memAddr,
	output logic [WORD_W-1:0]       memData,
	output logic [3:0]              dmaChannel,
	output logic                    runStart,
	output logic [IADDR_W-1:0]      runAddr,
	output logic                    bootDone,
	input  wire logic [7:0]         regAddr,
	input  wire logic [31:0]        regWrData,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic [31:0]             regRdData
);

	// ======================================================
	// functions
	function automatic mode_t decodeMode(input logic eb, input logic lb,
			input logic sel, input logic bmsHigh);
		mode_t m;
		m = MODE_RESERVED;
		if (VARIANT == VAR_ONE_SEL) begin
			if (sel)
				m = MODE_EPROM;
			else if (bmsHigh)
				m = MODE_HOST;
			else
				m = MODE_NONE;
		end else if (eb && !lb) begin
			m = MODE_EPROM;
		end else if (!eb && lb && bmsHigh) begin
			m = MODE_LINK;
		end else if (!eb && !lb && bmsHigh) begin
			m = MODE_HOST;
		end else if (!eb && !lb && !bmsHigh) begin
			m = MODE_NONE;
		end
		return m;
	endfunction

	function automatic logic [3:0] channelFor(input mode_t m);
		logic [3:0] c;
		c = 4'h0;
		if (m == MODE_EPROM || m == MODE_HOST || m == MODE_LINK) begin
			if (VARIANT != VAR_LARGE)
				c = CH_SIX;
			else if (m == MODE_LINK)
				c = CH_EIGHT;
			else
				c = CH_TEN;
		end
		return c;
	endfunction

	function automatic logic [WORD_W-1:0] placeUnit(
			input logic [WORD_W-1:0] w, input logic [15:0] u,
			input logic [5:0] p, input logic [5:0] width);
		logic [16:0] m;
		m = (17'h1 << width) - 17'h1;
		return w | (WORD_W'(u & m[15:0]) << p);
	endfunction

	// ======================================================
	// state
	state_t             state_q;
	mode_t              mode_q;
	logic [2:0]         ctrl_q;
	logic [WORD_W-1:0]  word_q;
	logic [5:0]         ptr_q;
	logic [8:0]         count_q;
	logic               take;
	logic [15:0]        unitData;
	logic [5:0]         unitWidth;
	logic               wordEnd;
	logic               lastWord;
	logic               epromActive;

	assign epromActive = (mode_q == MODE_EPROM) && ctrl_q[CTRL_OVERRIDE];

	// ======================================================
	// unit selection
	always_comb begin
		take = 1'b0;
		unitData = extData;
		unitWidth = UNIT_EPROM;
		if (state_q == S_WAIT) begin
			take = extValid;
			unitData = {8'h00, extData[7:0]};
		end else if (state_q == S_COLLECT && mode_q == MODE_HOST) begin
			take = extValid;
			unitWidth = ctrl_q[CTRL_HOST16] ? UNIT_HOST16 : UNIT_HOST8;
		end else if (state_q == S_COLLECT && mode_q == MODE_LINK) begin
			take = linkValid;
			unitData = {12'h000, linkData};
			unitWidth = UNIT_LINK;
		end
		wordEnd = (ptr_q + unitWidth) >= WORD_BITS;
		lastWord = wordEnd && (count_q == 9'(KERNEL_WORDS - 1));
	end

	// ======================================================
	// boot sequence
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_SAMPLE;
			mode_q <= MODE_NONE;
			epromReq <= 1'b0;
			epromAddr <= '0;
			runStart <= 1'b0;
			runAddr <= '0;
			bootDone <= 1'b0;
			dmaChannel <= 4'h0;
		end else begin
			epromReq <= 1'b0;
			runStart <= 1'b0;
			case (state_q)
				S_SAMPLE: begin
					mode_q <= decodeMode(eprom_boot_strap, link_boot_strap,
						eprom_select_strap, bootMemorySelectIn_n);
					epromAddr <= EPROM_BASE;
					state_q <= S_START;
				end
				S_START: begin
					dmaChannel <= channelFor(mode_q);
					case (mode_q)
						MODE_EPROM: state_q <= S_FETCH;
						MODE_HOST: state_q <= S_COLLECT;
						MODE_LINK: state_q <= S_COLLECT;
						MODE_NONE: state_q <= S_RUN;
						default: state_q <= S_HALT;
					endcase
				end
				S_FETCH: begin
					epromReq <= 1'b1;
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					if (take) begin
						epromAddr <= epromAddr + 24'h1;
						state_q <= lastWord ? S_RUN : S_FETCH;
					end
				end
				S_COLLECT: begin
					if (take && lastWord)
						state_q <= S_RUN;
				end
				S_RUN: begin
					runStart <= 1'b1;
					bootDone <= 1'b1;
					if (mode_q == MODE_NONE)
						runAddr <= NOBOOT_ADDR;
					else
						runAddr <= START_ADDR;
					state_q <= S_DONE;
				end
				S_DONE: state_q <= S_DONE;
				default: state_q <= S_HALT;
			endcase
		end
	end

	// ======================================================
	// word assembly
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_q <= '0;
			ptr_q <= 6'h00;
			count_q <= 9'h000;
			memWrite <= 1'b0;
			memAddr <= '0;
			memData <= '0;
		end else begin
			memWrite <= 1'b0;
			if (take) begin
				if (wordEnd) begin
					memData <= placeUnit(word_q, unitData, ptr_q,
						unitWidth);
					memAddr <= START_ADDR + IADDR_W'(count_q);
					memWrite <= 1'b1;
					count_q <= count_q + 9'h001;
					word_q <= '0;
					ptr_q <= 6'h00;
				end else begin
					word_q <= placeUnit(word_q, unitData, ptr_q,
						unitWidth);
					ptr_q <= ptr_q + unitWidth;
				end
			end
		end
	end

	// ======================================================
	// select pin and memory selects
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bootMemorySelectOut_n <= 1'b1;
			bootMemorySelectOe_n <= 1'b1;
			extSelectEnable <= 1'b0;
		end else begin
			bootMemorySelectOut_n <= !(epromActive &&
				(state_q == S_FETCH || state_q == S_WAIT));
			bootMemorySelectOe_n <= !(epromActive && busMaster &&
				!ctrl_q[CTRL_TRISTATE]);
			extSelectEnable <= state_q != S_SAMPLE && !epromActive;
		end
	end

	// ======================================================
	// register port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (regWr && regAddr == REG_CTRL) begin
			ctrl_q <= regWrData[2:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 32'h0;
		end else if (regRd && regAddr == REG_CTRL) begin
			regRdData <= {29'h0, ctrl_q};
		end else if (regRd && regAddr == REG_STATUS) begin
			regRdData <= {20'h0, LINK_BUFFER, dmaChannel,
				state_q == S_HALT, bootDone, mode_q};
		end else if (regRd && regAddr == REG_COUNT) begin
			regRdData <= {23'h0, count_q};
		end else begin
			regRdData <= 32'h0;
		end
	end

	// ======================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	word_limit_a: assert property (memWrite |-> count_q <= 9'h100)
		else $error("more than 256 kernel words written");
	word_write_a: assert property (take && wordEnd |=> memWrite)
		else $error("full word not written");
	eprom_only_a: assert property (epromReq |-> mode_q == MODE_EPROM)
		else $error("eprom fetch outside eprom mode");
	mode_hold_a: assert property (state_q != S_SAMPLE &&
		$past(state_q) != S_SAMPLE |-> $stable(mode_q))
		else $error("boot mode changed after sampling");
	master_drive_a: assert property (!bootMemorySelectOe_n |->
		$past(busMaster) && mode_q == MODE_EPROM)
		else $error("select driven without bus mastership");
	float_pin_a: assert property (ctrl_q[CTRL_TRISTATE] |=>
		bootMemorySelectOe_n)
		else $error("select pin not floated");
	release_sel_a: assert property (!ctrl_q[CTRL_OVERRIDE] &&
		state_q != S_SAMPLE |=> extSelectEnable &&
		bootMemorySelectOut_n)
		else $error("select not released after override clear");
	end_start_a: assert property (take && lastWord |=> ##1
		runStart && runAddr == START_ADDR && memAddr ==
		START_ADDR + 20'h000ff)
		else $error("run did not start after kernel load");
	noboot_run_a: assert property (state_q == S_START &&
		mode_q == MODE_NONE |=> ##1 runStart &&
		runAddr == NOBOOT_ADDR)
		else $error("no-boot start address wrong");
	chan_sel_a: assert property (state_q == S_FETCH |->
		dmaChannel == (VARIANT == VAR_LARGE ? CH_TEN : CH_SIX))
		else $error("wrong boot dma channel");
	link_chan_a: assert property (state_q == S_COLLECT &&
		mode_q == MODE_LINK |->
		dmaChannel == (VARIANT == VAR_LARGE ? CH_EIGHT : CH_SIX))
		else $error("wrong link boot channel");
	link_mode_a: assert property (VARIANT != VAR_ONE_SEL &&
		state_q == S_START && $past(!eprom_boot_strap &&
		link_boot_strap && bootMemorySelectIn_n) |-> mode_q == MODE_LINK)
		else $error("link straps not decoded as link boot");
	eprom_sel_a: assert property (!bootMemorySelectOut_n |->
		mode_q == MODE_EPROM && $past(ctrl_q[CTRL_OVERRIDE]))
		else $error("eprom select outside eprom boot");
	sel_exclusive_a: assert property (!bootMemorySelectOut_n |->
		!extSelectEnable)
		else $error("normal selects enabled during eprom select");
	halt_quiet_a: assert property (state_q == S_HALT |-> !memWrite &&
		!runStart && !bootDone && dmaChannel == 4'h0)
		else $error("reserved straps left outputs active");
	noboot_quiet_a: assert property (mode_q == MODE_NONE |->
		!memWrite && !epromReq && bootMemorySelectOe_n)
		else $error("no-boot mode touched the boot path");

	eprom_done_c: cover property (runStart && mode_q == MODE_EPROM);
	host_done_c: cover property (runStart && mode_q == MODE_HOST);
	link_done_c: cover property (runStart && mode_q == MODE_LINK);
	noboot_c: cover property (runStart && mode_q == MODE_NONE);
	halt_c: cover property (state_q == S_HALT);

endmodule

/* File: test/eprom_model.sv */
// boot eprom model answering byte requests under chip select
`timescale 1ns/1ps

module eprom_model #(
	parameter int SLOW = 3
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        req,
	input  wire logic [23:0] addr,
	input  wire logic        sel_n,
	input  wire logic        oe_n,
	output logic             valid,
	output logic [15:0]      data
);
	int          waitQ;
	logic [23:0] heldQ;

	// ====================================
	// byte answers, odd addresses answer slowly
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			valid <= 1'b0;
			data <= 16'hffff;
			waitQ <= -1;
			heldQ <= 24'h0;
		end else begin
			valid <= 1'b0;
			// released bus keeps toggling, back to the last byte every second cycle
			data <= ~data;
			if (req && !sel_n && !oe_n) begin
				waitQ <= addr[0] ? SLOW : 0;
				heldQ <= addr;
			end else if (waitQ == 0) begin
				valid <= 1'b1;
				// upper lane is junk: byte wide, low aligned
				data <= {~heldQ[7:0], heldQ[7:0] ^ heldQ[15:8] ^ 8'h5a};
				waitQ <= -1;
			end else if (waitQ > 0) begin
				waitQ <= waitQ - 1;
			end
		end
	end
endmodule

/* File: test/tb_top.sv */
// testbench for eprom, host, link, no-boot and reserved boots
`timescale 1ns/1ps

module tb_top;
	import boot_loader_pkg::*;
	localparam logic [23:0] EBASE = 24'h400000;
	localparam logic [19:0] START = 20'h20000;
	logic        clk, arst_n, eStrap, lStrap, selIn, epMode, master;
	logic        tbValid, mdlValid, extValid, linkValid, regWr, regRd;
	logic [15:0] tbData, mdlData, extData;
	logic [3:0]  linkData, dmaChannel;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData, rnd;
	logic        selOut_n, selOe_n, selPin_n, extSelEn, epromReq;
	logic        memWrite, runStart, bootDone;
	logic [23:0] epromAddr;
	logic [19:0] memAddr, runAddr;
	logic [47:0] memData, word;
	logic [23:0] ea;
	logic [67:0] expQ[$];
	int          errors, checksDone;

	// two-way select pin resolved from both drivers
	assign selPin_n = selOe_n ? selIn : selOut_n;
	assign extValid = epMode ? mdlValid : tbValid;
	assign extData = epMode ? mdlData : tbData;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	boot_mode_select_loader #(.EPROM_BASE(EBASE)) dut_u (
		.clk(clk), .arst_n(arst_n), .eprom_boot_strap(eStrap),
		.link_boot_strap(lStrap), .eprom_select_strap(1'b0),
		.bootMemorySelectIn_n(selPin_n), .bootMemorySelectOut_n(selOut_n),
		.bootMemorySelectOe_n(selOe_n), .busMaster(master),
		.extSelectEnable(extSelEn), .epromReq(epromReq),
		.epromAddr(epromAddr), .extValid(extValid), .extData(extData),
		.linkValid(linkValid), .linkData(linkData), .memWrite(memWrite),
		.memAddr(memAddr), .memData(memData), .dmaChannel(dmaChannel),
		.runStart(runStart), .runAddr(runAddr), .bootDone(bootDone),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData));

	eprom_model prom_u (.clk(clk), .arst_n(arst_n), .req(epromReq),
		.addr(epromAddr), .sel_n(selOut_n), .oe_n(selOe_n),
		.valid(mdlValid), .data(mdlData));

	// ====================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input logic [67:0] seen, input logic [67:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic boot(input logic e, input logic l, input logic s,
		input logic m);
		@(posedge clk);
		arst_n <= 1'b0;
		eStrap <= e;
		lStrap <= l;
		selIn <= s;
		epMode <= m;
		expQ.delete();
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic regRead(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 0;
		@(negedge clk);
		check(regRdData, e);
	endtask

	task automatic waitDone();
		int n;
		n = 0;
		while (bootDone !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			finish_test();
		end
	endtask

	// host or link stream, every unit back to back, low unit first
	task automatic sendWords(input int w, input logic link);
		logic [47:0] sh;
		for (int i = 0; i < KERNEL_WORDS; i++) begin
			rnd = lfsr(rnd);
			word[47:16] = rnd;
			rnd = lfsr(rnd);
			word[15:0] = rnd[15:0];
			expQ.push_back({START + 20'(i), word});
			for (int u = 0; u < 48 / w; u++) begin
				sh = word >> (u * w);
				@(posedge clk);
				tbValid <= !link;
				linkValid <= link;
				tbData <= (w == 16) ? sh[15:0] : {rnd[31:24], sh[7:0]};
				linkData <= sh[3:0];
			end
		end
		@(posedge clk);
		tbValid <= 1'b0;
		linkValid <= 1'b0;
		linkData <= ~linkData;
	endtask

	// ====================================
	// memory write monitor
	always @(posedge clk) begin
		if (memWrite === 1'b1) begin
			if (expQ.size() > 0) check({memAddr, memData}, expQ.pop_front());
			else check(memWrite, 1'b0);
		end
	end

	// ====================================
	// main sequence
	initial begin
		{eStrap, lStrap, epMode, tbValid, linkValid, regWr, regRd} = 7'h0;
		{tbData, linkData, regAddr, regWrData} = 60'h0;
		arst_n = 1'b0;
		selIn = 1'b1;
		master = 1'b1;
		rnd = 32'h05de0700;
		errors = 0;
		checksDone = 0;
		boot(1'b1, 1'b0, 1'b1, 1'b1);
		for (int i = 0; i < KERNEL_WORDS; i++) begin
			for (int b = 0; b < 6; b++) begin
				ea = EBASE + 24'(i * 6 + b);
				word[b * 8 +: 8] = ea[7:0] ^ ea[15:8] ^ 8'h5a;
			end
			expQ.push_back({START + 20'(i), word});
		end
		repeat (4) @(posedge clk);
		check({selOe_n, extSelEn, dmaChannel}, {2'b00, CH_SIX});
		waitDone();
		check({runAddr, 20'(expQ.size())}, {START, 20'h0});
		regRead(REG_STATUS, {20'h0, 3'h4, CH_SIX, 2'b01, MODE_EPROM});
		regRead(REG_COUNT, 32'h100);
		regRead(8'h0c, 32'h0);
		@(posedge clk);
		master <= 1'b0;
		repeat (2) @(posedge clk);
		check(selOe_n, 1'b1);
		master <= 1'b1;
		repeat (2) @(posedge clk);
		check(selOe_n, 1'b0);
		regWrite(REG_CTRL, 32'h3);
		repeat (2) @(posedge clk);
		check(selOe_n, 1'b1);
		regWrite(REG_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({selOe_n, extSelEn}, 2'b11);
		$display("eprom boot test done");
		for (int m = 0; m < 3; m++) begin
			boot(1'b0, m == 2, 1'b1, 1'b0);
			regRead(REG_CTRL, {29'h0, CTRL_RESET});
			if (m == 1) regWrite(REG_CTRL, 32'h5);
			// straps move after sampling; mode must hold
			eStrap <= 1'b1;
			sendWords(m == 1 ? 16 : (m == 2 ? 4 : 8), m == 2);
			waitDone();
			check({dmaChannel, runAddr, 20'(expQ.size())}, {CH_SIX, START, 20'h0});
			$display("stream boot test %0d done", m);
		end
		boot(1'b0, 1'b0, 1'b0, 1'b0);
		waitDone();
		regRead(REG_STATUS, {20'h0, 3'h4, 4'h0, 2'b01, MODE_NONE});
		$display("no-boot test done");
		for (int r = 0; r < 2; r++) begin
			boot(r[0], 1'b1, 1'b0, 1'b0);
			repeat (20) @(posedge clk);
			check({bootDone, dmaChannel, memWrite}, 6'h0);
			regRead(REG_STATUS, {20'h0, 3'h4, 4'h0, 2'b10, MODE_RESERVED});
		end
		$display("reserved test done");
		finish_test();
	end
endmodule
